// ---- rtl/aro_pkg.sv ----
// package for the converter result and offset register bank
// assumes a 250 MHz ref_clk and a 32-bit APB register bus
package aro_pkg;
	// ----------------------------------------
	// register byte addresses
	// ----------------------------------------
	localparam logic [31:0] ADDR_PRI_RESULT = 32'hffff051c;
	localparam logic [31:0] ADDR_AUX_RESULT = 32'hffff0520;
	localparam logic [31:0] ADDR_PRI_OFFSET = 32'hffff0524;
	localparam logic [31:0] ADDR_CONV_STATUS = 32'hffff0540;
	localparam logic [31:0] ADDR_CONV_MODE = 32'hffff0544;
	localparam logic [31:0] ADDR_INT_STATUS = 32'hffff0548;
	localparam logic [31:0] ADDR_INT_MASK = 32'hffff054c;
	// ----------------------------------------
	// widths, fields and reset values
	// ----------------------------------------
	localparam int RES_W = 24;
	localparam int OFS_W = 16;
	localparam int INT_W = 3;
	localparam logic [RES_W-1:0] RESULT_RST = 24'h000000;
	localparam int STA_RDY0 = 0;
	localparam int STA_RDY1 = 1;
	localparam int STA_CAL = 2;
	localparam int MODE_EN = 0;
	localparam int MODE_LSB = 1;
	localparam logic [1:0] MODE_IDLE = 2'h0;
	localparam logic [1:0] MODE_CONT = 2'h1;
	localparam logic [1:0] MODE_OFS_CAL = 2'h2;
	localparam logic [1:0] MODE_RST = 2'h0;
	localparam int INT_RDY0 = 0;
	localparam int INT_RDY1 = 1;
	localparam int INT_CAL = 2;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 4;
	localparam int IDLE_MIN_NS = 23000;
	localparam int IDLE_MIN_CYC = (IDLE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int IDLE_CNT_W = 13;
endpackage : aro_pkg

// ---- rtl/aro_reg_if.sv ----
// register access strobes between the APB slave and the register core
// assumes one clock shared by both ends
`timescale 1ns/1ns
`default_nettype none
interface aro_reg_if;
	logic wr_stb;
	logic rd_stb;
	logic setup;
	logic [31:0] addr;
	logic [31:0] wdata;
	logic wr_dir;
	logic [31:0] rdata;
	logic err;
	modport slave (output wr_stb, rd_stb, setup, addr, wdata, wr_dir, input rdata, err);
	modport core (input wr_stb, rd_stb, setup, addr, wdata, wr_dir, output rdata, err);
endinterface : aro_reg_if
`default_nettype wire

// ---- rtl/aro_apb_slave.sv ----
// APB slave front end: one wait-free access phase per transfer
// assumes the core answers rdata and err combinationally in the setup cycle
`timescale 1ns/1ns
`default_nettype none
module aro_apb_slave
	import aro_pkg::*;
(
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// apb
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// core side
	aro_reg_if.slave rif
);
	logic pready_reg, pready_next;
	logic pslverr_reg, pslverr_next;
	logic [31:0] prdata_reg, prdata_next;
	logic done;

	// ----------------------------------------
	// decode
	// ----------------------------------------
	assign done = psel && penable && pready_reg;
	assign rif.setup = psel && !penable;
	assign rif.addr = paddr;
	assign rif.wdata = pwdata;
	assign rif.wr_dir = pwrite;
	// a refused write never reaches the core
	assign rif.wr_stb = done && pwrite && !pslverr_reg;
	assign rif.rd_stb = done && !pwrite;

	always_comb begin
		pready_next = psel && !penable;
		prdata_next = prdata_reg;
		pslverr_next = pslverr_reg;
		if (srst) begin
			pready_next = 1'b0;
			prdata_next = 32'h00000000;
			pslverr_next = 1'b0;
		end else if (rif.setup) begin
			// decision frozen at setup so the answer cannot shift mid transfer
			prdata_next = pwrite ? 32'h00000000 : rif.rdata;
			pslverr_next = rif.err;
		end else if (done) begin
			pslverr_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		pready_reg <= pready_next;
		prdata_reg <= prdata_next;
		pslverr_reg <= pslverr_next;
	end

	assign pready = pready_reg;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;
endmodule : aro_apb_slave
`default_nettype wire

// ---- rtl/aro_irq.sv ----
// sticky event status, write-one-to-clear, with mask and level interrupt
// assumes event pulses and write strobes on ref_clk
`timescale 1ns/1ns
`default_nettype none
module aro_irq
	import aro_pkg::*;
#(
	parameter int W = INT_W
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// events and software access
	input wire logic [W-1:0] event_in,
	input wire logic clr_wr,
	input wire logic mask_wr,
	input wire logic [W-1:0] wdata,
	// state
	output logic [W-1:0] status,
	output logic [W-1:0] mask,
	output logic irq
);
	logic [W-1:0] status_reg, status_next;
	logic [W-1:0] mask_reg, mask_next;
	logic irq_reg, irq_next;

	always_comb begin
		status_next = status_reg;
		mask_next = mask_reg;
		if (clr_wr) begin
			status_next = status_next & ~wdata;
		end
		// set wins over a clear in the same cycle
		status_next = status_next | event_in;
		if (mask_wr) begin
			mask_next = wdata;
		end
		if (srst) begin
			status_next = '0;
			mask_next = '0;
		end
		irq_next = |(status_next & mask_next);
	end

	always_ff @(posedge ref_clk) begin
		status_reg <= status_next;
		mask_reg <= mask_next;
		irq_reg <= irq_next;
	end

	assign status = status_reg;
	assign mask = mask_reg;
	assign irq = irq_reg;
endmodule : aro_irq
`default_nettype wire

// ---- rtl/aro_regs.sv ----
// converter result and primary offset register bank, APB slave
// assumes converter results, calibration value and factory offset on ref_clk
//
// Notes on behaviour
// - primary result read-only, 24 bits, resets zero
// - primary result held while primary ready set
// - reading primary result clears both ready flags
// - auxiliary result read-only, 24 bits, resets zero
// - auxiliary result held while auxiliary ready set
// - primary offset coefficient readable and writable, 16 bits
// - offset loads factory value at reset
// - offset calibration replaces offset with measured value
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
module aro_regs
	import aro_pkg::*;
#(
	parameter int IDLE_CYCLES = IDLE_MIN_CYC
) (
	// clock and reset
	input wire logic ref_clk,
	input wire logic srst,
	// apb
	input wire logic [31:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// converter results
	input wire logic conv0_valid,
	input wire logic [RES_W-1:0] conv0_data,
	input wire logic conv1_valid,
	input wire logic [RES_W-1:0] conv1_data,
	// calibration and factory value
	input wire logic cal_done,
	input wire logic [OFS_W-1:0] cal_value,
	input wire logic [OFS_W-1:0] factory_offset,
	// converter control
	output logic conv0_enable,
	output logic [1:0] conv0_mode,
	output logic cal_start,
	output logic [OFS_W-1:0] conv0_offset,
	// interrupt
	output logic irq
);
	aro_reg_if rif ();

	logic [RES_W-1:0] res0_reg, res0_next;
	logic [RES_W-1:0] res1_reg, res1_next;
	logic rdy0_reg, rdy0_next;
	logic rdy1_reg, rdy1_next;
	logic [OFS_W-1:0] ofs_reg, ofs_next;
	logic en_reg, en_next;
	logic [1:0] mode_reg, mode_next;
	logic cal_busy_reg, cal_busy_next;
	logic cal_start_reg, cal_start_next;
	logic [IDLE_CNT_W-1:0] idle_cnt_reg, idle_cnt_next;
	logic hold_pri;
	logic load0, load1;
	logic rd_pri;
	logic ofs_wr_ok;
	logic idle_long;
	logic [INT_W-1:0] int_events;
	logic [INT_W-1:0] int_status, int_mask;

	// ----------------------------------------
	// bus front end
	// ----------------------------------------
	aro_apb_slave u_apb (
		.ref_clk(ref_clk),
		.srst(srst),
		.paddr(paddr),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.pwdata(pwdata),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.rif(rif)
	);

	// ----------------------------------------
	// result capture
	// ----------------------------------------
	// a pending read of the primary result freezes loading, so a sample
	// cannot land after read data is latched and then be cleared unread
	assign hold_pri = psel && !pwrite && (paddr == ADDR_PRI_RESULT);
	assign rd_pri = rif.rd_stb && (rif.addr == ADDR_PRI_RESULT);
	assign load0 = conv0_valid && !rdy0_reg && !hold_pri;
	assign load1 = conv1_valid && !rdy1_reg && !hold_pri;

	always_comb begin
		res0_next = res0_reg;
		res1_next = res1_reg;
		rdy0_next = rdy0_reg;
		rdy1_next = rdy1_reg;
		if (rd_pri) begin
			rdy0_next = 1'b0;
			rdy1_next = 1'b0;
		end
		// result registers have no write path at all
		if (load0) begin
			res0_next = conv0_data;
			rdy0_next = 1'b1;
		end
		if (load1) begin
			res1_next = conv1_data;
			rdy1_next = 1'b1;
		end
		if (srst) begin
			res0_next = RESULT_RST;
			res1_next = RESULT_RST;
			rdy0_next = 1'b0;
			rdy1_next = 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		res0_reg <= res0_next;
		res1_reg <= res1_next;
		rdy0_reg <= rdy0_next;
		rdy1_reg <= rdy1_next;
	end

	// ----------------------------------------
	// mode, calibration and offset
	// ----------------------------------------
	assign idle_long = (idle_cnt_reg >= IDLE_CNT_W'(IDLE_CYCLES));
	// coefficient writes outside an enabled, settled idle are refused
	assign ofs_wr_ok = en_reg && (mode_reg == MODE_IDLE) && idle_long;

	always_comb begin
		ofs_next = ofs_reg;
		en_next = en_reg;
		mode_next = mode_reg;
		cal_busy_next = cal_busy_reg;
		cal_start_next = 1'b0;
		idle_cnt_next = idle_cnt_reg;
		if (en_reg && (mode_reg == MODE_IDLE)) begin
			if (!idle_long) begin
				idle_cnt_next = idle_cnt_reg + IDLE_CNT_W'(1);
			end
		end else begin
			idle_cnt_next = '0;
		end
		if (rif.wr_stb && (rif.addr == ADDR_CONV_MODE)) begin
			en_next = rif.wdata[MODE_EN];
			mode_next = rif.wdata[MODE_LSB+1:MODE_LSB];
			idle_cnt_next = '0;
			if (rif.wdata[MODE_EN] && (rif.wdata[MODE_LSB+1:MODE_LSB] == MODE_OFS_CAL)) begin
				cal_busy_next = 1'b1;
				cal_start_next = 1'b1;
			end else begin
				cal_busy_next = 1'b0;
			end
		end
		if (rif.wr_stb && (rif.addr == ADDR_PRI_OFFSET)) begin
			ofs_next = rif.wdata[OFS_W-1:0];
		end
		if (cal_done && cal_busy_reg) begin
			ofs_next = cal_value;
			cal_busy_next = 1'b0;
			mode_next = MODE_IDLE;
		end
		if (srst) begin
			ofs_next = factory_offset;
			en_next = 1'b0;
			mode_next = MODE_RST;
			cal_busy_next = 1'b0;
			cal_start_next = 1'b0;
			idle_cnt_next = '0;
		end
	end

	always_ff @(posedge ref_clk) begin
		ofs_reg <= ofs_next;
		en_reg <= en_next;
		mode_reg <= mode_next;
		cal_busy_reg <= cal_busy_next;
		cal_start_reg <= cal_start_next;
		idle_cnt_reg <= idle_cnt_next;
	end

	assign conv0_enable = en_reg;
	assign conv0_mode = mode_reg;
	assign cal_start = cal_start_reg;
	assign conv0_offset = ofs_reg;

	// ----------------------------------------
	// interrupts
	// ----------------------------------------
	always_comb begin
		int_events = '0;
		int_events[INT_RDY0] = load0;
		int_events[INT_RDY1] = load1;
		int_events[INT_CAL] = cal_done && cal_busy_reg;
	end

	aro_irq #(
		.W(INT_W)
	) u_irq (
		.ref_clk(ref_clk),
		.srst(srst),
		.event_in(int_events),
		.clr_wr(rif.wr_stb && (rif.addr == ADDR_INT_STATUS)),
		.mask_wr(rif.wr_stb && (rif.addr == ADDR_INT_MASK)),
		.wdata(rif.wdata[INT_W-1:0]),
		.status(int_status),
		.mask(int_mask),
		.irq(irq)
	);

	// ----------------------------------------
	// read mux and error decode
	// ----------------------------------------
	always_comb begin
		rif.rdata = 32'h00000000;
		rif.err = 1'b0;
		case (rif.addr)
			ADDR_PRI_RESULT: rif.rdata = {8'h00, res0_reg};
			ADDR_AUX_RESULT: rif.rdata = {8'h00, res1_reg};
			ADDR_PRI_OFFSET: begin
				rif.rdata = {16'h0000, ofs_reg};
				rif.err = rif.wr_dir && !ofs_wr_ok;
			end
			ADDR_CONV_STATUS: begin
				rif.rdata[STA_RDY0] = rdy0_reg;
				rif.rdata[STA_RDY1] = rdy1_reg;
				rif.rdata[STA_CAL] = cal_busy_reg;
			end
			ADDR_CONV_MODE: begin
				rif.rdata[MODE_EN] = en_reg;
				rif.rdata[MODE_LSB+1:MODE_LSB] = mode_reg;
			end
			ADDR_INT_STATUS: rif.rdata[INT_W-1:0] = int_status;
			ADDR_INT_MASK: rif.rdata[INT_W-1:0] = int_mask;
			default: rif.err = 1'b1;
		endcase
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	AST_RES0_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
		rdy0_reg && !rd_pri |=> $stable(res0_reg))
		else $error("primary result changed while ready set");

	AST_RES1_HOLD: assert property (@(posedge ref_clk) disable iff (srst)
		rdy1_reg && !rd_pri |=> $stable(res1_reg))
		else $error("auxiliary result changed while ready set");

	AST_READ_CLEARS: assert property (@(posedge ref_clk) disable iff (srst)
		rd_pri && !conv1_valid |=> !rdy0_reg && !rdy1_reg)
		else $error("primary read did not clear ready flags");

	AST_LOAD0: assert property (@(posedge ref_clk) disable iff (srst)
		conv0_valid && !rdy0_reg && !hold_pri
		|=> rdy0_reg && (res0_reg == $past(conv0_data)))
		else $error("primary result not captured");

	AST_LOAD1: assert property (@(posedge ref_clk) disable iff (srst)
		conv1_valid && !rdy1_reg && !hold_pri
		|=> rdy1_reg && (res1_reg == $past(conv1_data)))
		else $error("auxiliary result not captured");

	AST_RO_IGNORED: assert property (@(posedge ref_clk) disable iff (srst)
		rif.wr_stb && ((rif.addr == ADDR_PRI_RESULT) || (rif.addr == ADDR_AUX_RESULT))
		&& !conv0_valid && !conv1_valid
		|=> $stable(res0_reg) && $stable(res1_reg) && $stable(rdy0_reg))
		else $error("write to result register had an effect");

	AST_CAL_LOAD: assert property (@(posedge ref_clk) disable iff (srst)
		cal_done && cal_busy_reg |=> (ofs_reg == $past(cal_value)) && (mode_reg == MODE_IDLE))
		else $error("calibration value not loaded");

	AST_FACTORY: assert property (@(posedge ref_clk) disable iff (srst)
		$fell(srst) |-> (ofs_reg == $past(factory_offset)))
		else $error("offset not loaded from factory value");

	AST_OFS_GATE: assert property (@(posedge ref_clk) disable iff (srst)
		psel && penable && pready && pwrite && (paddr == ADDR_PRI_OFFSET) && pslverr
		&& !cal_done |=> $stable(ofs_reg))
		else $error("refused offset write changed the coefficient");

	AST_OFS_WRITE: assert property (@(posedge ref_clk) disable iff (srst)
		psel && penable && pready && pwrite && (paddr == ADDR_PRI_OFFSET) && !pslverr
		&& !(cal_done && cal_busy_reg) |=> (ofs_reg == $past(pwdata[OFS_W-1:0])))
		else $error("accepted offset write not stored");

	AST_IDLE_TIME: assert property (@(posedge ref_clk) disable iff (srst)
		psel && penable && pready && pwrite && (paddr == ADDR_PRI_OFFSET) && !pslverr
		|-> conv0_enable && (conv0_mode == MODE_IDLE)
		&& (idle_cnt_reg >= IDLE_CNT_W'(IDLE_CYCLES)))
		else $error("offset write accepted before idle time elapsed");
endmodule : aro_regs
`default_nettype wire

// ---- testbench/aro_regs_tb.sv ----
// self-checking bench for the converter result and offset register bank
// assumes the bench alone drives apb, converter and calibration inputs
`timescale 1ns/1ns
`default_nettype none
module aro_regs_tb;
	import aro_pkg::*;
	// ----------------------------------------
	// signals
	// ----------------------------------------
	localparam int IDLE = 8;
	localparam logic [OFS_W-1:0] FACTORY = 16'h3c5a;
	localparam logic [OFS_W-1:0] FACTORY2 = 16'hc3a5;
	logic ref_clk = 1'b0;
	logic srst = 1'b1;
	logic [31:0] paddr = 32'h0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic conv0_valid = 1'b0;
	logic [RES_W-1:0] conv0_data = 24'h0;
	logic conv1_valid = 1'b0;
	logic [RES_W-1:0] conv1_data = 24'h0;
	logic cal_done = 1'b0;
	logic [OFS_W-1:0] cal_value = 16'h0;
	logic [OFS_W-1:0] factory_val = FACTORY;
	logic conv0_enable;
	logic [1:0] conv0_mode;
	logic cal_start;
	logic [OFS_W-1:0] conv0_offset;
	logic irq;
	int n_fail = 0;
	int checked = 0;
	logic [31:0] rd;
	logic er;

	aro_regs #(.IDLE_CYCLES(IDLE)) i_aro_regs (.ref_clk(ref_clk), .srst(srst), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .conv0_valid(conv0_valid),
		.conv0_data(conv0_data), .conv1_valid(conv1_valid), .conv1_data(conv1_data),
		.cal_done(cal_done), .cal_value(cal_value), .factory_offset(factory_val),
		.conv0_enable(conv0_enable), .conv0_mode(conv0_mode), .cal_start(cal_start),
		.conv0_offset(conv0_offset), .irq(irq));

	initial begin
		forever #2 ref_clk = ~ref_clk;
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : finish_test

	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// one apb transfer; the request stands until pready is sampled high or 50 cycles pass
	task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			chk("pready", 32'(pready), 32'h1);
		end
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rchk(input string nm, input logic [31:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(nm, rd, exp);
		chk("read error", 32'(er), 32'h0);
	endtask : rchk

	task automatic wchk(input logic [31:0] a, input logic [31:0] d, input logic exp_err);
		apb(1'b1, a, d);
		chk("write error", 32'(er), {31'h0, exp_err});
	endtask : wchk

	// k 0 primary, 1 auxiliary, 2 calibration done
	task automatic pulse(input int k, input logic [23:0] d);
		@(posedge ref_clk);
		if (k == 0) begin
			conv0_valid <= 1'b1;
			conv0_data <= d;
		end else if (k == 1) begin
			conv1_valid <= 1'b1;
			conv1_data <= d;
		end else begin
			cal_done <= 1'b1;
			cal_value <= d[15:0];
		end
		@(posedge ref_clk);
		conv0_valid <= 1'b0;
		conv1_valid <= 1'b0;
		cal_done <= 1'b0;
	endtask : pulse

	// ----------------------------------------
	// watchdog: the sequence needs well under a thousand cycles
	// ----------------------------------------
	initial begin
		repeat (20000) @(posedge ref_clk);
		n_fail++;
		finish_test();
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (6) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		chk("offset port", 32'(conv0_offset), 32'(FACTORY));
		chk("enable", 32'(conv0_enable), 32'h0);
		chk("irq", 32'(irq), 32'h0);
		rchk("pri reset", ADDR_PRI_RESULT, 32'h0);
		rchk("aux reset", ADDR_AUX_RESULT, 32'h0);
		rchk("ofs reset", ADDR_PRI_OFFSET, {16'h0, FACTORY});
		// second sample while ready is pending must be dropped
		pulse(0, 24'habcdef);
		pulse(0, 24'h123456);
		pulse(1, 24'h00f00d);
		pulse(1, 24'h777777);
		rchk("status", ADDR_CONV_STATUS, 32'h3);
		wchk(ADDR_PRI_RESULT, 32'hffffffff, 1'b0);
		wchk(ADDR_AUX_RESULT, 32'hffffffff, 1'b0);
		rchk("status kept", ADDR_CONV_STATUS, 32'h3);
		rchk("aux held", ADDR_AUX_RESULT, 32'h00f00d);
		rchk("aux no clear", ADDR_CONV_STATUS, 32'h3);
		// interrupt masked, then unmasked, then cleared
		chk("irq masked", 32'(irq), 32'h0);
		wchk(ADDR_INT_MASK, 32'h3, 1'b0);
		repeat (2) @(posedge ref_clk);
		chk("irq on", 32'(irq), 32'h1);
		rchk("int status", ADDR_INT_STATUS, 32'h3);
		rchk("pri held", ADDR_PRI_RESULT, 32'habcdef);
		rchk("ready cleared", ADDR_CONV_STATUS, 32'h0);
		wchk(ADDR_INT_STATUS, 32'h3, 1'b0);
		repeat (2) @(posedge ref_clk);
		chk("irq off", 32'(irq), 32'h0);
		rchk("int cleared", ADDR_INT_STATUS, 32'h0);
		// after the clear both channels load again
		pulse(0, 24'h0000aa);
		pulse(1, 24'h5a5a5a);
		rchk("pri reload", ADDR_PRI_RESULT, 32'h0000aa);
		rchk("aux reload", ADDR_AUX_RESULT, 32'h5a5a5a);
		// drop the reload events so only the calibration event shows later
		wchk(ADDR_INT_STATUS, 32'h3, 1'b0);
		apb(1'b0, 32'hffff0530, 32'h0);
		chk("unmapped err", 32'(er), 32'h1);
		chk("unmapped data", rd, 32'h0);
		// offset writes: refused while disabled, too soon, or running
		wchk(ADDR_PRI_OFFSET, 32'h1111, 1'b1);
		wchk(ADDR_CONV_MODE, 32'h1, 1'b0);
		wchk(ADDR_PRI_OFFSET, 32'h2222, 1'b1);
		repeat (IDLE + 4) @(posedge ref_clk);
		wchk(ADDR_PRI_OFFSET, 32'hbeef, 1'b0);
		rchk("ofs rw", ADDR_PRI_OFFSET, 32'hbeef);
		chk("offset port", 32'(conv0_offset), 32'h0000beef);
		wchk(ADDR_CONV_MODE, 32'h3, 1'b0);
		wchk(ADDR_PRI_OFFSET, 32'h3333, 1'b1);
		rchk("ofs kept", ADDR_PRI_OFFSET, 32'hbeef);
		// offset calibration overwrites the coefficient
		wchk(ADDR_CONV_MODE, 32'h5, 1'b0);
		@(posedge ref_clk);
		chk("cal start", 32'(cal_start), 32'h1);
		chk("cal mode", 32'(conv0_mode), {30'h0, MODE_OFS_CAL});
		pulse(2, 24'h001357);
		rchk("ofs cal", ADDR_PRI_OFFSET, 32'h1357);
		rchk("mode idle", ADDR_CONV_MODE, 32'h1);
		rchk("cal int", ADDR_INT_STATUS, 32'h4);
		chk("irq cal masked", 32'(irq), 32'h0);
		// a calibration value arriving while not calibrating is ignored
		pulse(2, 24'h002468);
		rchk("ofs no cal", ADDR_PRI_OFFSET, 32'h1357);
		// second reset reloads whatever factory value is present then
		srst <= 1'b1;
		factory_val <= FACTORY2;
		repeat (2) @(posedge ref_clk);
		srst <= 1'b0;
		@(posedge ref_clk);
		chk("offset port", 32'(conv0_offset), 32'(FACTORY2));
		chk("irq", 32'(irq), 32'h0);
		rchk("pri reset", ADDR_PRI_RESULT, 32'h0);
		rchk("ofs reset", ADDR_PRI_OFFSET, {16'h0, FACTORY2});
		rchk("mode reset", ADDR_CONV_MODE, 32'h0);
		finish_test();
	end
endmodule : aro_regs_tb
`default_nettype wire
